// >>> hdl/gpfs_pkg.sv
// Package for the low-power pin function selector: register map, field layout,
// reset values and the carrier structs of the APB port.
// Assumes a 32-bit APB with byte addresses equal to the absolute register addresses.
package gpfs_pkg;

   //////////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int PIN_CNT = 8;
   localparam int SEL_W = 3;
   localparam int SEL_STRIDE = 4;
   localparam int FUNC_CNT = 8;
   localparam int CODE_W = 6;
   localparam int CODE_STRIDE = 8;
   localparam int CODES_PER_REG = 4;
   localparam int XBAR_CNT = 64;
   localparam int XBAR_REGS = 2;
   localparam int MISC_REGS = 7;

   //////////////////////////////////////////////////////////////////////////////
   // Register addresses
   localparam logic [31:0] ADDR_SEL0 = 32'h4000B044;
   localparam logic [31:0] ADDR_XBAR0 = 32'h4000B1A0;
   localparam logic [31:0] ADDR_XBAR1 = 32'h4000B1A4;
   localparam logic [31:0] ADDR_XBAR2 = 32'h4000B1A8;
   localparam logic [31:0] ADDR_XBAR3 = 32'h4000B1AC;
   localparam logic [31:0] ADDR_XBAR4 = 32'h4000B1B0;
   localparam logic [31:0] ADDR_XBAR5 = 32'h4000B1B4;
   localparam logic [31:0] ADDR_XBAR6 = 32'h4000B1B8;
   localparam logic [31:0] ADDR_AON_SEL = 32'h4000F000;
   localparam logic [31:0] ADDR_MS_MODE = 32'h4000F410;

   //////////////////////////////////////////////////////////////////////////////
   // Field masks and reset values
   localparam logic [31:0] SEL_MASK = 32'h77777777;
   localparam logic [31:0] XBAR_MASK = 32'h3F3F3F3F;
   localparam logic [31:0] SEL0_RST = 32'h00000022;
   localparam logic [31:0] XBAR_RST = 32'h00000000;
   localparam logic [31:0] MISC_RST = 32'h00000000;
   localparam logic [SEL_W-1:0] SEL_CROSSBAR = 3'h1;

   //////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } gpfs_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } gpfs_apb_rsp_t;

endpackage : gpfs_pkg

// >>> hdl/gpfs_top.sv
// Function selector for low-power pins 0 to 7 with its crossbar, behind an APB slave.
// Assumes APB in the clk_in domain and peripheral signals synchronous to clk_in.
`timescale 1ns/100ps

module gpfs_top (
   // Clock, reset, enable
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // APB slave
   input wire gpfs_pkg::gpfs_apb_req_t apb_in,
   output gpfs_pkg::gpfs_apb_rsp_t apb_out,
   // Fixed peripheral functions, per pin and function number (slot 1 is unused)
   input wire logic [gpfs_pkg::PIN_CNT-1:0][gpfs_pkg::FUNC_CNT-1:0] fix_drive_in,
   input wire logic [gpfs_pkg::PIN_CNT-1:0][gpfs_pkg::FUNC_CNT-1:0] fix_oe_in,
   output logic [gpfs_pkg::PIN_CNT-1:0][gpfs_pkg::FUNC_CNT-1:0] fix_sense_out,
   // Crossbar peripheral signals, indexed by crossbar function code
   input wire logic [gpfs_pkg::XBAR_CNT-1:0] xbar_drive_in,
   input wire logic [gpfs_pkg::XBAR_CNT-1:0] xbar_oe_in,
   output logic [gpfs_pkg::XBAR_CNT-1:0] xbar_sense_out,
   // Low-power pins
   input wire logic [gpfs_pkg::PIN_CNT-1:0] low_power_pin_in,
   output logic [gpfs_pkg::PIN_CNT-1:0] low_power_pin_out,
   output logic [gpfs_pkg::PIN_CNT-1:0] low_power_pin_oe_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [31:0] sel;
      logic [gpfs_pkg::XBAR_REGS-1:0][31:0] xbar;
      logic [gpfs_pkg::MISC_REGS-1:0][31:0] misc;
      gpfs_pkg::gpfs_apb_rsp_t rsp;
      logic [gpfs_pkg::PIN_CNT-1:0] pin_drive;
      logic [gpfs_pkg::PIN_CNT-1:0] pin_oe;
      logic [gpfs_pkg::PIN_CNT-1:0][gpfs_pkg::FUNC_CNT-1:0] fix_sense;
      logic [gpfs_pkg::XBAR_CNT-1:0] xbar_sense;
   } gpfs_state_t;

   gpfs_state_t state_r;
   gpfs_state_t state_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic [gpfs_pkg::SEL_W-1:0] code;
      logic [gpfs_pkg::CODE_W-1:0] xcode;
      logic [31:0] rdata;
      logic hit;
      code = '0;
      xcode = '0;
      rdata = '0;
      hit = 1'b1;
      state_nxt = state_r;

      // Read decode, shared by the setup-phase answer and the error check
      unique case (apb_in.paddr)
         gpfs_pkg::ADDR_SEL0: rdata = state_r.sel & gpfs_pkg::SEL_MASK;
         gpfs_pkg::ADDR_XBAR0: rdata = state_r.xbar[0] & gpfs_pkg::XBAR_MASK;
         gpfs_pkg::ADDR_XBAR1: rdata = state_r.xbar[1] & gpfs_pkg::XBAR_MASK;
         gpfs_pkg::ADDR_XBAR2: rdata = state_r.misc[0];
         gpfs_pkg::ADDR_XBAR3: rdata = state_r.misc[1];
         gpfs_pkg::ADDR_XBAR4: rdata = state_r.misc[2];
         gpfs_pkg::ADDR_XBAR5: rdata = state_r.misc[3];
         gpfs_pkg::ADDR_XBAR6: rdata = state_r.misc[4];
         gpfs_pkg::ADDR_AON_SEL: rdata = state_r.misc[5];
         gpfs_pkg::ADDR_MS_MODE: rdata = state_r.misc[6];
         default: hit = 1'b0;
      endcase

      // Answer one cycle after setup: pready rises in the access phase
      state_nxt.rsp.pready = 1'b0;
      if (apb_in.psel && !apb_in.penable) begin
         state_nxt.rsp.pready = 1'b1;
         state_nxt.rsp.pslverr = !hit;
         state_nxt.rsp.prdata = apb_in.pwrite ? 32'h00000000 : rdata;
      end

      // Writes take effect only at the completing edge of the access phase
      if (apb_in.psel && apb_in.penable && state_r.rsp.pready && apb_in.pwrite && hit) begin
         unique case (apb_in.paddr)
            gpfs_pkg::ADDR_SEL0: state_nxt.sel = apb_in.pwdata & gpfs_pkg::SEL_MASK;
            gpfs_pkg::ADDR_XBAR0: state_nxt.xbar[0] = apb_in.pwdata & gpfs_pkg::XBAR_MASK;
            gpfs_pkg::ADDR_XBAR1: state_nxt.xbar[1] = apb_in.pwdata & gpfs_pkg::XBAR_MASK;
            gpfs_pkg::ADDR_XBAR2: state_nxt.misc[0] = apb_in.pwdata;
            gpfs_pkg::ADDR_XBAR3: state_nxt.misc[1] = apb_in.pwdata;
            gpfs_pkg::ADDR_XBAR4: state_nxt.misc[2] = apb_in.pwdata;
            gpfs_pkg::ADDR_XBAR5: state_nxt.misc[3] = apb_in.pwdata;
            gpfs_pkg::ADDR_XBAR6: state_nxt.misc[4] = apb_in.pwdata;
            gpfs_pkg::ADDR_AON_SEL: state_nxt.misc[5] = apb_in.pwdata;
            default: state_nxt.misc[6] = apb_in.pwdata;
         endcase
      end

      // Pin routing from the stored codes; outputs lag the register by one cycle
      state_nxt.fix_sense = '0;
      state_nxt.xbar_sense = '0;
      for (int i = 0; i < gpfs_pkg::PIN_CNT; i++) begin
         code = state_r.sel[i*gpfs_pkg::SEL_STRIDE +: gpfs_pkg::SEL_W];
         xcode = state_r.xbar[i/gpfs_pkg::CODES_PER_REG]
                 [(i%gpfs_pkg::CODES_PER_REG)*gpfs_pkg::CODE_STRIDE +: gpfs_pkg::CODE_W];
         if (code == gpfs_pkg::SEL_CROSSBAR) begin
            state_nxt.pin_drive[i] = xbar_drive_in[xcode];
            state_nxt.pin_oe[i] = xbar_oe_in[xcode];
            // Two pins on one code both feed it; the sense is their OR
            state_nxt.xbar_sense[xcode] = state_nxt.xbar_sense[xcode] | low_power_pin_in[i];
         end else begin
            state_nxt.pin_drive[i] = fix_drive_in[i][code];
            state_nxt.pin_oe[i] = fix_oe_in[i][code];
            state_nxt.fix_sense[i][code] = low_power_pin_in[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_r.sel <= gpfs_pkg::SEL0_RST;
         state_r.xbar <= {gpfs_pkg::XBAR_REGS{gpfs_pkg::XBAR_RST}};
         state_r.misc <= {gpfs_pkg::MISC_REGS{gpfs_pkg::MISC_RST}};
         state_r.rsp <= '0;
         state_r.pin_drive <= '0;
         state_r.pin_oe <= '0;
         state_r.fix_sense <= '0;
         state_r.xbar_sense <= '0;
      end else if (ce_in) begin
         state_r <= state_nxt;
      end
   end

   assign apb_out = state_r.rsp;
   assign fix_sense_out = state_r.fix_sense;
   assign xbar_sense_out = state_r.xbar_sense;
   assign low_power_pin_out = state_r.pin_drive;
   assign low_power_pin_oe_out = state_r.pin_oe;

endmodule : gpfs_top

// >>> tb/gpfs_checker.sv
// Checker for the pin selector: APB answer timing, read masks, routing causes.
// Assumes bind into gpfs_top with ce_in held high.
`timescale 1ns/100ps
module gpfs_checker (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // Watched ports
   input wire gpfs_pkg::gpfs_apb_req_t apb_in,
   input wire gpfs_pkg::gpfs_apb_rsp_t apb_out,
   input wire logic [7:0][7:0] fix_oe_in,
   input wire logic [7:0][7:0] fix_sense_out,
   input wire logic [63:0] xbar_oe_in,
   input wire logic [63:0] xbar_sense_out,
   input wire logic [7:0] low_power_pin_in,
   input wire logic [7:0] low_power_pin_oe_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   //////////////////////////////////////////////////////////////////////////////
   a_ready_next: assert property (apb_in.psel && !apb_in.penable && ce_in |=> apb_out.pready)
      else $error("no ready after setup");
   a_ready_drop: assert property (apb_out.pready && ce_in |=> !apb_out.pready)
      else $error("ready held too long");
   a_sel_mask: assert property (apb_out.pready && apb_in.paddr == gpfs_pkg::ADDR_SEL0 && !apb_in.pwrite
      |-> (apb_out.prdata & ~gpfs_pkg::SEL_MASK) == 32'h0) else $error("unused bits read high");
   // First routed cycle after release must already use the reset codes
   a_reset_route: assert property (!$past(rstn_in) && ce_in |=> fix_sense_out[1:0] ==
      {5'h0, $past(low_power_pin_in[1]), 2'h0, 5'h0, $past(low_power_pin_in[0]), 2'h0}) else $error("reset route");
   a_one_func: assert property ($onehot0(fix_sense_out[7]) && !fix_sense_out[0][1])
      else $error("pin seen by two functions");
   a_sense_cause: assert property (fix_sense_out[7] != 8'h0 |-> $past(low_power_pin_in[7]))
      else $error("sense without pin level");
   a_xbar_cause: assert property (xbar_sense_out != 64'h0 |-> $past(low_power_pin_in) != 8'h0)
      else $error("crossbar sense without pin");
   a_oe_cause: assert property (low_power_pin_oe_out[0] |-> $past(fix_oe_in[0]) != 8'h0 || $past(xbar_oe_in) != 64'h0)
      else $error("pin driven without enable");
endmodule : gpfs_checker

// >>> tb/test_gpio_pin_function_select.sv
// Bench: APB access to the selector and crossbar codes, then routing checks.
// Assumes ce_in high, 100 ns clock, reads checked by a queue monitor.
`timescale 1ns/100ps
module test_gpio_pin_function_select;
   logic clk_in, rstn_in;
   gpfs_pkg::gpfs_apb_req_t req;
   gpfs_pkg::gpfs_apb_rsp_t rsp;
   logic [7:0][7:0] fd, fo, fs;
   logic [63:0] xd, xo, xs;
   logic [7:0] pin, po, poe;
   logic [32:0] q[$];
   logic [31:0] s;
   int err_total, check_count;
   gpfs_top i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1), .apb_in(req), .apb_out(rsp),
      .fix_drive_in(fd), .fix_oe_in(fo), .fix_sense_out(fs), .xbar_drive_in(xd), .xbar_oe_in(xo),
      .xbar_sense_out(xs), .low_power_pin_in(pin), .low_power_pin_out(po), .low_power_pin_oe_out(poe));
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   //////////////////////////////////////////////////////////////////////////////
   task check(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   // Leading edge wait keeps two requests from landing in one time step
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [32:0] exp);
      @(posedge clk_in);
      req <= '{1'b1, 1'b0, w, a, d};
      if (!w) q.push_back(exp);
      @(posedge clk_in);
      req.penable <= 1'b1;
      do @(posedge clk_in); while (rsp.pready !== 1'b1);
      req <= '0;
   endtask : apb
   always @(posedge clk_in) begin
      if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite && q.size() > 0) begin
         check({rsp.pslverr, rsp.prdata}, q.pop_front());
      end
   end
   task route(input logic [31:0] sel);
      logic [2:0] c;
      logic [63:0] xe;
      xe = '0;
      @(posedge clk_in);
      pin <= 8'($urandom);
      fd <= {$urandom, $urandom};
      fo <= {$urandom, $urandom};
      xd <= {$urandom, $urandom};
      xo <= {$urandom, $urandom};
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      for (int p = 0; p < 8; p++) begin
         c = sel[4*p +: 3];
         check(33'(fs[p]), c == 3'h1 ? 33'h0 : 33'(pin[p]) << c);
         if (c == 3'h1) begin
            check(33'(xs[8+p]), 33'(pin[p]));
            xe[8+p] = pin[p];
            check(33'({poe[p], po[p] & poe[p]}), 33'({xo[8+p], xd[8+p] & xo[8+p]}));
         end else begin
            check(33'({poe[p], po[p] & poe[p]}), 33'({fo[p][c], fd[p][c] & fo[p][c]}));
         end
      end
      // Codes that no routed pin uses must see nothing
      check(33'(xs[63:32]), 33'(xe[63:32]));
      check(33'(xs[31:0]), 33'(xe[31:0]));
   endtask : route
   initial begin
      req = '0;
      {fd, fo, xd, xo, pin} = '0;
      rstn_in = 1'b0;
      s = $urandom(32'hA28DDF5C);
      repeat (20) @(posedge clk_in);
      rstn_in <= 1'b1;
      apb(1'b0, gpfs_pkg::ADDR_SEL0, 32'h0, {1'b0, gpfs_pkg::SEL0_RST});
      route(gpfs_pkg::SEL0_RST);
      apb(1'b1, gpfs_pkg::ADDR_XBAR0, 32'h0B0A0908, 33'h0);
      apb(1'b1, gpfs_pkg::ADDR_XBAR1, 32'h0F0E0D0C, 33'h0);
      apb(1'b0, gpfs_pkg::ADDR_XBAR1, 32'h0, 33'h00F0E0D0C);
      apb(1'b1, gpfs_pkg::ADDR_XBAR2, 32'h12345678, 33'h0);
      apb(1'b0, gpfs_pkg::ADDR_XBAR2, 32'h0, 33'h012345678);
      apb(1'b1, gpfs_pkg::ADDR_MS_MODE, 32'hA5A5A5A5, 33'h0);
      apb(1'b0, gpfs_pkg::ADDR_MS_MODE, 32'h0, 33'h0A5A5A5A5);
      apb(1'b1, gpfs_pkg::ADDR_SEL0, 32'hFFFFFFFF, 33'h0);
      apb(1'b0, gpfs_pkg::ADDR_SEL0, 32'h0, 33'h077777777);
      apb(1'b1, 32'h4000B048, 32'h1, 33'h0);
      apb(1'b0, 32'h4000B048, 32'h0, 33'h100000000);
      for (int i = 0; i < 8; i++) begin
         s = i == 0 ? 32'h76543210 : i == 1 ? 32'h11111111 : $urandom & gpfs_pkg::SEL_MASK;
         apb(1'b1, gpfs_pkg::ADDR_SEL0, s, 33'h0);
         route(s);
      end
      give_verdict();
   end
   initial begin
      #500us;
      err_total++;
      give_verdict();
   end
endmodule : test_gpio_pin_function_select
bind gpfs_top gpfs_checker i_chk (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .apb_in(apb_in),
   .apb_out(apb_out), .fix_oe_in(fix_oe_in), .fix_sense_out(fix_sense_out), .xbar_oe_in(xbar_oe_in),
   .xbar_sense_out(xbar_sense_out), .low_power_pin_in(low_power_pin_in), .low_power_pin_oe_out(low_power_pin_oe_out));
